// ==== design/touch_pkg.sv ====
// Constants for the touch detect decision logic: thresholds, drift rates, timers.
// Assumes an 8-bit burst measurement, 100 MHz sys_clk and a 1 ms tick derived from it.
package touch_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Measurement format
    localparam int unsigned SAMPLE_W       = 8;
    localparam int unsigned FULL_SCALE     = 32'h0000_0100;   // 256 levels

    // Thresholds in hundredths of a percent of full scale
    localparam int unsigned PCT_DENOM      = 32'h0000_2710;   // 10000
    localparam int unsigned PCT_HALF       = 32'h0000_1388;   // Rounding term
    localparam int unsigned THR_HIGH_CPCT  = 32'h0000_0136;   // 3.10 percent
    localparam int unsigned THR_MED_CPCT   = 32'h0000_01D6;   // 4.70 percent
    localparam int unsigned THR_LOW_CPCT   = 32'h0000_0271;   // 6.25 percent
    localparam int unsigned HYST_PCT       = 32'h0000_0032;   // 50 percent of threshold
    localparam int unsigned PCT_FULL       = 32'h0000_0064;   // 100 percent

    // Gain strap codes
    localparam logic [1:0]  GAIN_SEL_HIGH  = 2'h0;
    localparam logic [1:0]  GAIN_SEL_MED   = 2'h1;
    localparam logic [1:0]  GAIN_SEL_LOW   = 2'h2;

    // Filter and timing
    localparam int unsigned CONSENSUS_LEN  = 32'h0000_0004;   // Samples
    localparam int unsigned POS_DRIFT_MS   = 32'h0000_02EE;   // 750 ms per level
    localparam int unsigned NEG_DRIFT_MS   = 32'h0000_004B;   // 75 ms per level
    localparam int unsigned RECAL_SHORT_S  = 32'h0000_000A;   // 10 s
    localparam int unsigned RECAL_LONG_S   = 32'h0000_003C;   // 60 s
    localparam int unsigned PULSE_MS       = 32'h0000_004B;   // 75 ms
    localparam int unsigned MS_PER_S       = 32'h0000_03E8;
    localparam int unsigned CLK_HZ         = 32'h05F5_E100;   // 100 MHz
    localparam int unsigned MS_CYCLES      = CLK_HZ / MS_PER_S;
    localparam int unsigned MS_W           = 16;              // Holds 60000 ms

    // Decision states
    typedef enum logic [1:0] {
        ST_CAL,
        ST_IDLE,
        ST_TOUCH
    } touch_state_t;

    // Fraction of full scale, rounded to the nearest level
    function automatic logic [SAMPLE_W-1:0] level_of(input int unsigned cpct);
        int unsigned lv;
        lv = (FULL_SCALE * cpct + PCT_HALF) / PCT_DENOM;
        return lv[SAMPLE_W-1:0];
    endfunction

endpackage

// ==== design/ms_tick.sv ====
// Millisecond tick generator for the touch decision timers.
// Assumes one free-running sys_clk; tick is a one-cycle pulse from a flip-flop.
`timescale 1ns/1ps

module ms_tick #(
    parameter int unsigned TICK_CYCLES = touch_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // Tick
    output logic      tick
);

    localparam int unsigned CW = $clog2(TICK_CYCLES + 1);

    initial begin
        if (TICK_CYCLES < 1) begin
            $error("ms_tick: TICK_CYCLES must be at least 1");
        end
    end

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic          next_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Down counter, reloads on terminal count
    always_comb begin
        next_tick  = 1'b0;
        next_count = count - 1'b1;
        if (count == '0) begin
            next_tick  = 1'b1;
            next_count = CW'(TICK_CYCLES - 1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            count <= CW'(TICK_CYCLES - 1);
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end

endmodule // ms_tick

// ==== design/touch_detect.sv ====
// Touch detect decision logic: threshold, hysteresis, consensus, drift, recalibration.
// Assumes the front end delivers one 8-bit measurement with a one-cycle valid per burst
// and that strap inputs are steady and synchronous to sys_clk.
`timescale 1ns/1ps

module touch_detect #(
    parameter int unsigned TICK_CYCLES = touch_pkg::MS_CYCLES,
    parameter int unsigned CONSENSUS   = touch_pkg::CONSENSUS_LEN
) (
    // Clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            reset_n,
    // Burst measurement
    input  wire logic                            sample_valid,
    input  wire logic [touch_pkg::SAMPLE_W-1:0]  sample,
    // Option straps
    input  wire logic [1:0]                      gain_sel,
    input  wire logic                            long_timeout,
    input  wire logic                            pulse_mode,
    // Results
    output logic                                 detect_out,
    output logic                                 touch_active,
    output logic                                 calibrated,
    output logic [touch_pkg::SAMPLE_W-1:0]       reference
);

    localparam int unsigned SW = touch_pkg::SAMPLE_W;
    localparam int unsigned MW = touch_pkg::MS_W;
    localparam int unsigned CCW = $clog2(CONSENSUS + 1);

    initial begin
        if (CONSENSUS < 1 || CONSENSUS > 15) begin
            $error("touch_detect: CONSENSUS out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fixed thresholds per gain, computed at elaboration
    localparam logic [SW-1:0] THR_HIGH = touch_pkg::level_of(touch_pkg::THR_HIGH_CPCT);
    localparam logic [SW-1:0] THR_MED  = touch_pkg::level_of(touch_pkg::THR_MED_CPCT);
    localparam logic [SW-1:0] THR_LOW  = touch_pkg::level_of(touch_pkg::THR_LOW_CPCT);
    localparam logic [MW-1:0] POS_MS   = MW'(touch_pkg::POS_DRIFT_MS);
    localparam logic [MW-1:0] NEG_MS   = MW'(touch_pkg::NEG_DRIFT_MS);
    localparam logic [MW-1:0] PULS_MS  = MW'(touch_pkg::PULSE_MS);
    localparam logic [MW-1:0] SHORT_MS = MW'(touch_pkg::RECAL_SHORT_S * touch_pkg::MS_PER_S);
    localparam logic [MW-1:0] LONG_MS  = MW'(touch_pkg::RECAL_LONG_S * touch_pkg::MS_PER_S);

    // Saturating millisecond count
    function automatic logic [MW-1:0] ms_step(input logic [MW-1:0] v, input logic t);
        return (t && v != '1) ? v + 1'b1 : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Shared millisecond tick
    logic tick;

    ms_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Threshold and deviation
    logic [SW-1:0] thr;
    logic [SW-1:0] rel_thr;
    logic [SW:0]   dev_up;
    logic          above;
    logic          below;
    logic          over_thr;
    logic          under_rel;

    always_comb begin
        unique case (gain_sel)
            touch_pkg::GAIN_SEL_HIGH: thr = THR_HIGH;
            touch_pkg::GAIN_SEL_MED:  thr = THR_MED;
            default:                  thr = THR_LOW;    // Unused code reads as low gain
        endcase
        rel_thr   = thr - SW'((thr * touch_pkg::HYST_PCT) / touch_pkg::PCT_FULL);
        above     = sample > reference;
        below     = sample < reference;
        dev_up    = above ? ({1'b0, sample} - {1'b0, reference}) : '0;
        over_thr  = dev_up > {1'b0, thr};
        under_rel = dev_up < {1'b0, rel_thr};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decision state, consensus, drift and recalibration
    touch_pkg::touch_state_t state;
    touch_pkg::touch_state_t next_state;
    logic [CCW-1:0]          agree;
    logic [CCW-1:0]          next_agree;
    logic [SW-1:0]           next_reference;
    logic [MW-1:0]           up_ms;
    logic [MW-1:0]           next_up_ms;
    logic [MW-1:0]           down_ms;
    logic [MW-1:0]           next_down_ms;
    logic [MW-1:0]           hold_ms;
    logic [MW-1:0]           next_hold_ms;
    logic [MW-1:0]           recal_ms;

    always_comb begin
        next_state     = state;
        next_agree     = agree;
        next_reference = reference;
        next_up_ms     = ms_step(up_ms, tick);
        next_down_ms   = ms_step(down_ms, tick);
        next_hold_ms   = (state == touch_pkg::ST_TOUCH) ? ms_step(hold_ms, tick) : '0;
        recal_ms       = long_timeout ? LONG_MS : SHORT_MS;
        unique case (state)
            touch_pkg::ST_CAL: begin
                // First measurement becomes the reference
                if (sample_valid) begin
                    next_reference = sample;
                    next_agree     = '0;
                    next_up_ms     = '0;
                    next_down_ms   = '0;
                    next_state     = touch_pkg::ST_IDLE;
                end
            end
            touch_pkg::ST_IDLE: begin
                if (sample_valid) begin
                    // A disagreeing sample restarts the count
                    next_agree = over_thr ? agree + 1'b1 : '0;
                    if (over_thr && agree == CCW'(CONSENSUS - 1)) begin
                        next_agree = '0;
                        next_state = touch_pkg::ST_TOUCH;
                    end
                    if (above && up_ms >= POS_MS) begin
                        next_reference = reference + 1'b1;
                        next_up_ms     = '0;
                    end
                end
            end
            touch_pkg::ST_TOUCH: begin
                if (hold_ms >= recal_ms) begin
                    next_state = touch_pkg::ST_CAL;
                    next_agree = '0;
                end else if (sample_valid) begin
                    next_agree = under_rel ? agree + 1'b1 : '0;
                    if (under_rel && agree == CCW'(CONSENSUS - 1)) begin
                        next_agree = '0;
                        next_state = touch_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = touch_pkg::ST_CAL;
            end
        endcase
        // Falling drift is tracked in any calibrated state, so a dropping baseline
        // cannot leave a stuck detection behind
        if (state != touch_pkg::ST_CAL && sample_valid && below && down_ms >= NEG_MS) begin
            next_reference = reference - 1'b1;
            next_down_ms   = '0;
        end
        // The upward drift timer holds at the period so the next eligible sample acts at once
        if (!above) begin
            next_up_ms = (up_ms >= POS_MS) ? up_ms : next_up_ms;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state     <= touch_pkg::ST_CAL;
            agree     <= '0;
            reference <= '0;
            up_ms     <= '0;
            down_ms   <= '0;
            hold_ms   <= '0;
        end else begin
            state     <= next_state;
            agree     <= next_agree;
            reference <= next_reference;
            up_ms     <= next_up_ms;
            down_ms   <= next_down_ms;
            hold_ms   <= next_hold_ms;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output stage: level or fixed-width pulse
    logic          next_detect_out;
    logic          next_touch_active;
    logic          next_calibrated;
    logic [MW-1:0] pulse_ms;
    logic [MW-1:0] next_pulse_ms;
    logic          rise;

    always_comb begin
        next_touch_active = (next_state == touch_pkg::ST_TOUCH);
        next_calibrated   = (next_state != touch_pkg::ST_CAL);
        rise              = next_touch_active && !touch_active;
        next_pulse_ms     = pulse_ms;
        if (rise) begin
            next_pulse_ms = PULS_MS;
        end else if (tick && pulse_ms != '0) begin
            next_pulse_ms = pulse_ms - 1'b1;
        end
        // Pulse width counts whole ticks, so it may run short by under one ms
        next_detect_out = pulse_mode ? (next_pulse_ms != '0) : next_touch_active;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            detect_out   <= 1'b0;
            touch_active <= 1'b0;
            calibrated   <= 1'b0;
            pulse_ms     <= '0;
        end else begin
            detect_out   <= next_detect_out;
            touch_active <= next_touch_active;
            calibrated   <= next_calibrated;
            pulse_ms     <= next_pulse_ms;
        end
    end

endmodule // touch_detect

// ==== testbench/touch_chk.sv ====
// Checker for touch_detect: detection, drift, recalibration and pulse timing.
// Sees only the top ports; bound into every touch_detect below.
`timescale 1ns/1ps
module touch_chk #(
    parameter int unsigned TICK_CYCLES = 4,
    parameter int unsigned CONSENSUS   = 4
) (
    // Clock and reset
    input wire logic                           sys_clk,
    input wire logic                           reset_n,
    // Measurement and straps
    input wire logic                           sample_valid,
    input wire logic [touch_pkg::SAMPLE_W-1:0] sample,
    input wire logic [1:0]                     gain_sel,
    input wire logic                           long_timeout,
    input wire logic                           pulse_mode,
    // Results
    input wire logic                           detect_out,
    input wire logic                           touch_active,
    input wire logic                           calibrated,
    input wire logic [touch_pkg::SAMPLE_W-1:0] reference
);
    localparam int UP_MIN = 749 * TICK_CYCLES - 1;
    localparam int DN_MIN = 74 * TICK_CYCLES - 1;
    int         thr, lim, run, up_gap, dn_gap, hold, pw;
    logic [7:0] prev;
    logic       prev_cal;
    wire        up = calibrated && prev_cal && reference > prev;
    wire        dn = calibrated && prev_cal && reference < prev;

    ////////////////////////////////////////
    // Threshold and timeout for the straps
    always_comb thr = (gain_sel == 2'h0) ? 8 : (gain_sel == 2'h1) ? 12 : 16;
    always_comb lim = long_timeout ? 60000 : 10000;

    // Cycle counts since each event, run counts agreeing samples; ints never wrap within a run
    always_ff @(posedge sys_clk) begin
        prev     <= reference;
        prev_cal <= calibrated;
        if (sample_valid)
            run <= (int'(sample) > int'(reference) + thr) ? run + 1 : 0;
        up_gap <= (!calibrated || up) ? 0 : up_gap + 1;
        dn_gap <= (!calibrated || dn) ? 0 : dn_gap + 1;
        hold   <= touch_active ? hold + 1 : 0;
        pw     <= detect_out ? pw + 1 : 0;
    end

    ////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    ref_load_a : assert property (!calibrated && sample_valid |=> calibrated && reference == $past(sample))
        else $error("reference not loaded from first sample");
    thr_cross_a : assert property ($rose(touch_active) |->
        $past(sample_valid) && int'($past(sample)) > int'($past(reference)) + $past(thr))
        else $error("detection without threshold crossing");
    consensus_len_a : assert property ($rose(touch_active) |-> run >= CONSENSUS)
        else $error("detection before enough agreeing samples");
    hyst_release_a : assert property ($fell(touch_active) && calibrated |-> $past(sample_valid) &&
        int'($past(sample)) < int'($past(reference)) + $past(thr) - $past(thr) / 2)
        else $error("release above hysteresis limit");
    up_step_a : assert property (up |-> !$past(touch_active) && reference == prev + 8'h01 && up_gap >= UP_MIN)
        else $error("upward drift too fast or during detection");
    dn_step_a : assert property (dn |-> reference == prev - 8'h01 && dn_gap >= DN_MIN)
        else $error("downward drift too fast");
    recal_early_a : assert property ($fell(touch_active) && !calibrated |-> hold >= (lim - 1) * TICK_CYCLES)
        else $error("recalibration before timeout");
    recal_late_a : assert property (touch_active |-> hold <= (lim + 2) * TICK_CYCLES)
        else $error("detection held past timeout");
    level_out_a : assert property (!pulse_mode |-> detect_out == touch_active)
        else $error("level output differs from detection");
    pulse_len_a : assert property (pulse_mode |-> pw <= 75 * TICK_CYCLES)
        else $error("output pulse too long");
endmodule // touch_chk

bind touch_detect touch_chk #(.TICK_CYCLES(TICK_CYCLES), .CONSENSUS(CONSENSUS)) chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .sample_valid(sample_valid), .sample(sample),
    .gain_sel(gain_sel), .long_timeout(long_timeout), .pulse_mode(pulse_mode), .detect_out(detect_out),
    .touch_active(touch_active), .calibrated(calibrated), .reference(reference));

// ==== testbench/detect_host.sv ====
// Host model reading the detect line: counts rises, keeps last high width.
// Assumes detect_out is registered on sys_clk.
`timescale 1ns/1ps
module detect_host (
    // Clock
    input  wire logic sys_clk,
    // Detect line
    input  wire logic detect_out,
    // Observations
    output int        rises,
    output int        width
);
    int run;

    // Width in clocks, latched when the line drops
    always @(posedge sys_clk) begin
        run <= detect_out ? run + 1 : 0;
        if (!detect_out && run > 0)
            width <= run;
        if (detect_out && run == 0)
            rises <= rises + 1;
    end
endmodule // detect_host

// ==== testbench/tb_touch_detect_signal_processing.sv ====
// Self-checking bench for touch_detect against an integer model.
// Assumes TICK_CYCLES of 4, so one millisecond is four clocks.
`timescale 1ns/1ps
module tb_touch_detect_signal_processing;
    localparam int T = 4;
    logic       sys_clk = 1'h0;
    logic       reset_n = 1'h0;
    logic       sample_valid = 1'h0;
    logic       long_timeout = 1'h0;
    logic       pulse_mode = 1'h0;
    logic [7:0] sample = 8'h00;
    logic [1:0] gain_sel = 2'h0;
    logic       detect_out, touch_active, calibrated;
    logic [7:0] reference;
    int         rises, width, n_fail, samples_checked, seed, cyc, mref, mact, mcnt, mcal, thr;
    int         cp [4] = '{310, 470, 625, 625}; // Code 3 acts as low gain

    touch_detect #(.TICK_CYCLES(T)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .sample_valid(sample_valid),
        .sample(sample), .gain_sel(gain_sel), .long_timeout(long_timeout), .pulse_mode(pulse_mode),
        .detect_out(detect_out), .touch_active(touch_active), .calibrated(calibrated), .reference(reference));
    detect_host host (.sys_clk(sys_clk), .detect_out(detect_out), .rises(rises), .width(width));

    ////////////////////////////////////////
    always #5 sys_clk = ~sys_clk;

    // Hang guard, above the two 10 s holds and everything around them
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (n_fail == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input int exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp[7:0]) begin
            n_fail++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Reset also clears the model
    task automatic rst();
        reset_n = 1'h0;
        repeat (4) @(posedge sys_clk);
        #1 reset_n = 1'h1;
        mcal = 0;
        mact = 0;
        mcnt = 0;
    endtask

    // One-cycle valid, then a gap edge so valid never toggles twice at once
    task automatic put(input int v);
        @(posedge sys_clk);
        #1 sample_valid = 1'h1;
        sample = v[7:0];
        @(posedge sys_clk);
        #1 sample_valid = 1'h0;
    endtask

    // Wait whole clocks, then step off the edge so outputs have settled
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic drive_ms(input int v, input int n);
        repeat (n) begin
            put(v);
            wait_clk(T - 2);
        end
    endtask

    // Model step: first sample calibrates, then consensus on the active condition
    task automatic step(input int v);
        int d;
        put(v);
        d = v - mref;
        if (!mcal) begin
            mref = v;
            mcal = 1;
        end else begin
            mcnt = (mact ? d < thr - thr / 2 : d > thr) ? mcnt + 1 : 0;
            if (mcnt == 4) begin
                mact = !mact;
                mcnt = 0;
            end
        end
        chk("touch_active", mact, touch_active);
        chk("reference", mref, reference);
        if (!pulse_mode)
            chk("detect_out", mact, detect_out);
    endtask

    ////////////////////////////////////////
    initial begin
        int r0;
        seed = 70;
        rst();
        chk("calibrated", 0, calibrated);
        // Every gain code: restart, strict boundary, hysteresis edge
        for (int g = 0; g < 4; g++) begin
            gain_sel = g[1:0];
            thr = (256 * cp[g] + 5000) / 10000;
            rst();
            step(100);
            repeat (3) step(101 + thr + ($random(seed) & 3));
            step(100);
            repeat (4) step(100 + thr);
            repeat (4) step(101 + thr);
            repeat (4) step(100 + thr - thr / 2);
            repeat (4) step(99 + thr - thr / 2);
        end
        // Pulse mode: one pulse for each new detection
        gain_sel = 2'h0;
        thr = 8;
        pulse_mode = 1'h1;
        rst();
        step(100);
        r0 = rises;
        repeat (4) step(110);
        wait_clk(90 * T);
        chk("detect_out", 0, detect_out);
        chk("pulse_fit", 1, width > 74 * T && width <= 75 * T);
        repeat (4) step(100);
        repeat (4) step(110);
        wait_clk(90 * T);
        chk("pulses", r0 + 2, rises);
        // Drift down fast, then up slowly
        pulse_mode = 1'h0;
        rst();
        step(100);
        drive_ms(90, 80);
        chk("reference", 99, reference);
        drive_ms(101, 800);
        chk("reference", 100, reference);
        // No upward drift while touched, then forced recalibration
        mref = 100;
        repeat (4) step(110);
        drive_ms(110, 800);
        chk("reference", 100, reference);
        chk("touch_active", 1, touch_active);
        wait_clk(9300 * T);
        chk("touch_active", 0, touch_active);
        chk("calibrated", 0, calibrated);
        mcal = 0;
        mact = 0;
        mcnt = 0;
        step(120);
        // Long strap keeps detection past the short timeout
        long_timeout = 1'h1;
        repeat (4) step(130);
        wait_clk(10050 * T);
        chk("touch_active", 1, touch_active);
        chk("calibrated", 1, calibrated);
        tally_and_finish();
    end
endmodule // tb_touch_detect_signal_processing
